//--- core/uml_pkg.sv
`default_nettype none

package uml_pkg;

  // ***************************************************************
  // Register map (byte addresses, one aligned word each)
  // ***************************************************************
  localparam int unsigned ADDR_W   = 6;
  localparam logic [5:0]  OFF_DATA = 6'h00;
  localparam logic [5:0]  OFF_IER  = 6'h04;
  localparam logic [5:0]  OFF_MCR  = 6'h08;
  localparam logic [5:0]  OFF_LSR  = 6'h0c;
  localparam logic [5:0]  OFF_MSR  = 6'h10;
  localparam logic [5:0]  OFF_CFG  = 6'h14;
  localparam logic [5:0]  OFF_DIV  = 6'h18;
  localparam logic [5:0]  OFF_SRST = 6'h1c;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned MCR_DTR              = 0;
  localparam int unsigned MCR_RTS              = 1;
  localparam int unsigned MCR_FLOW_SEL         = 2;
  localparam int unsigned MCR_SPARE_OUTPUT_TWO = 3;
  localparam int unsigned MCR_LOOP             = 4;
  localparam int unsigned MCR_XON_ANY          = 5;
  localparam int unsigned MCR_IR_EN            = 6;
  localparam int unsigned MCR_PRESC            = 7;

  localparam int unsigned IER_RX  = 0;
  localparam int unsigned IER_THR = 1;
  localparam int unsigned IER_LS  = 2;
  localparam int unsigned IER_MS  = 3;

  localparam int unsigned CFG_FIFO_EN  = 0;
  localparam int unsigned CFG_AUTO_CTS = 1;
  localparam int unsigned CFG_IR_INV   = 2;
  localparam int unsigned CFG_PAR_EN   = 3;
  localparam int unsigned CFG_PAR_EVEN = 4;
  localparam int unsigned CFG_SW_HALT  = 5;

  // ***************************************************************
  // Reset values and timing counts
  // ***************************************************************
  localparam logic [3:0]  IER_RST      = 4'h0;
  localparam logic [5:0]  MCR_LOW_RST  = 6'h00;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam int unsigned DIV_RST      = 1;
  localparam int unsigned PRESC_DIV    = 4;
  localparam logic [3:0]  BIT_LAST     = 4'hf;
  localparam logic [3:0]  SAMPLE_MID   = 4'h7;
  localparam logic [3:0]  IR_PULSE     = 4'h3;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } uml_rx_char_t;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } uml_modem_in_t;

endpackage : uml_pkg

`default_nettype wire

//--- core/uml_channel.sv
// Function
// R1 - Control bit 4 enables internal loopback
// R2 - Bit 5: any received character resumes transmitter
// R3 - Bit 6 loads infrared strap at reset
// R4 - Infrared mode encodes/decodes, transmit idles low
// R5 - Bit 7 divides baud clock by four
// R6 - Line status interrupt on any receive error
// R7 - Reading line status clears bits 4..1
// R8 - Bit 0 shows received data waiting
// R9 - Overrun when FIFO full, FIFO untouched
// R10 - Parity/framing tags follow head character
// R11 - Break tag; one break character per condition
// R12 - Holding empty sets on move, clears on write
// R13 - Holding empty raises interrupt when enabled
// R14 - Transmitter empty only when fully idle
// R15 - FIFO error flag while errored character stored
// R16 - Delta flags for CTS, DSR, CD changes
// R17 - Ring delta only on low-to-high input
// R18 - Modem interrupt on any delta when enabled
// R19 - Auto CTS: high pauses after character
// R20 - Status bits 4..7 are inverted inputs
// R21 - Loopback status echoes control bits 1,0,2,3
// R22 - Control bit 3 writable, no pin
// R23 - Control bits 1,0 drive RTS/DTR low
// R24 - Loopback routes tx to rx, pins inactive
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module uml_channel
  import uml_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 64,
  parameter int unsigned DIV_W    = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              rx_i,
  output logic                   tx_o,
  input  wire uml_modem_in_t     modem_i,
  output logic                   rts_n_o,
  output logic                   dtr_n_o,
  input  wire logic              ir_strap_i,
  output logic                   irq_o
);

  localparam int unsigned PTR_W = $clog2(RX_DEPTH);
  localparam int unsigned CNT_W = $clog2(RX_DEPTH + 1);

  function automatic logic parity_bit(input logic [7:0] d, input logic even);
    parity_bit = (^d) ^ ~even;
  endfunction : parity_bit

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(RX_DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction : ptr_inc

  // ***************************************************************
  // Bus slave and soft reset
  // ***************************************************************
  logic              ack_r;
  logic [31:0]       dat_r;
  logic              srst_r;
  logic [3:0]        ier_r;
  logic [7:0]        mcr_r;
  logic [7:0]        cfg_r;
  logic [DIV_W-1:0]  div_r;

  wire core_rst  = rst_i | srst_r;
  wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr_req    = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_req    = bus_req & ~wb_we_i;
  wire hit_data  = wb_adr_i == OFF_DATA;
  wire hit_ier   = wb_adr_i == OFF_IER;
  wire hit_mcr   = wb_adr_i == OFF_MCR;
  wire hit_lsr   = wb_adr_i == OFF_LSR;
  wire hit_msr   = wb_adr_i == OFF_MSR;
  wire hit_cfg   = wb_adr_i == OFF_CFG;
  wire hit_div   = wb_adr_i == OFF_DIV;
  wire hit_srst  = wb_adr_i == OFF_SRST;
  wire wr_data   = wr_req & hit_data;
  wire rd_data   = rd_req & hit_data;
  wire rd_lsr    = rd_req & hit_lsr;
  wire rd_msr    = rd_req & hit_msr;
  wire loop_en   = mcr_r[MCR_LOOP];
  wire ir_en     = mcr_r[MCR_IR_EN];

  always_ff @(posedge clk_i)
  begin
    ack_r  <= rst_i ? 1'b0 : bus_req;
    srst_r <= rst_i ? 1'b0 : (wr_req & hit_srst & wb_dat_i[0]);
  end

  // ***************************************************************
  // Prescaler and 16x baud tick
  // ***************************************************************
  logic [1:0]       presc_r;
  logic [DIV_W-1:0] baud_r;

  wire presc_tick = ~mcr_r[MCR_PRESC] | (presc_r == 2'(PRESC_DIV - 1)); // R5
  wire baud_wrap  = (baud_r + DIV_W'(1)) >= div_r;
  wire tick       = presc_tick & baud_wrap;

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      presc_r <= 2'h0;
      baud_r  <= '0;
    end
    else
    begin
      presc_r <= presc_tick ? 2'h0 : 2'(presc_r + 2'h1);
      if (presc_tick)
        baud_r <= baud_wrap ? '0 : DIV_W'(baud_r + DIV_W'(1));
    end
  end

  // ***************************************************************
  // Modem inputs, loopback selection
  // ***************************************************************
  uml_modem_in_t modem_eff;
  uml_modem_in_t modem_prev_r;
  logic [3:0]    delta_r;

  assign modem_eff = loop_en ? uml_modem_in_t'({~mcr_r[MCR_SPARE_OUTPUT_TWO], // R21
                                                ~mcr_r[MCR_FLOW_SEL],
                                                ~mcr_r[MCR_DTR],
                                                ~mcr_r[MCR_RTS]})
                             : modem_i; // R20

  wire [3:0] delta_set = {modem_eff.cd_n ^ modem_prev_r.cd_n,                // R16
                          modem_eff.ri_n & ~modem_prev_r.ri_n,               // R17
                          modem_eff.dsr_n ^ modem_prev_r.dsr_n,
                          modem_eff.cts_n ^ modem_prev_r.cts_n};
  wire [7:0] msr_val   = {~modem_eff.cd_n, ~modem_eff.ri_n,
                          ~modem_eff.dsr_n, ~modem_eff.cts_n, delta_r};      // R20

  always_ff @(posedge clk_i)
  begin
    modem_prev_r <= modem_eff;
    if (core_rst)
      delta_r <= 4'h0;
    else
      delta_r <= delta_set | (delta_r & {4{~rd_msr}});
  end

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uml_tx_st_t;
  uml_tx_st_t tx_st_r;
  uml_tx_st_t tx_st_nxt;
  logic [7:0] thr_r;
  logic       thr_full_r;
  logic [7:0] tsr_r;
  logic       tx_par_r;
  logic [2:0] tx_bit_r;
  logic [3:0] tx_cnt_r;
  logic       tx_serial;

  wire tx_hold  = cfg_r[CFG_SW_HALT] | (cfg_r[CFG_AUTO_CTS] & modem_eff.cts_n); // R19
  wire tx_load  = (tx_st_r == TX_IDLE) & thr_full_r & ~tx_hold;
  wire tx_bend  = tick & (tx_cnt_r == BIT_LAST);
  wire tx_idle  = (tx_st_r == TX_IDLE);
  wire ir_pulse = ~tx_serial & (tx_cnt_r < IR_PULSE);                        // R4
  wire tx_pin   = loop_en ? ~ir_en : (ir_en ? ir_pulse : tx_serial);          // R24

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    tx_serial = 1'b1;
    case (tx_st_r)
      TX_IDLE:
      begin
        if (tx_load)
          tx_st_nxt = TX_START;
      end
      TX_START:
      begin
        tx_serial = 1'b0;
        if (tx_bend)
          tx_st_nxt = TX_DATA;
      end
      TX_DATA:
      begin
        tx_serial = tsr_r[0];
        if (tx_bend && tx_bit_r == 3'h7)
          tx_st_nxt = cfg_r[CFG_PAR_EN] ? TX_PAR : TX_STOP;
      end
      TX_PAR:
      begin
        tx_serial = tx_par_r;
        if (tx_bend)
          tx_st_nxt = TX_STOP;
      end
      TX_STOP:
      begin
        if (tx_bend)
          tx_st_nxt = TX_IDLE;
      end
      default:
      begin
        tx_st_nxt = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      tx_st_r    <= TX_IDLE;
      thr_full_r <= 1'b0;
      tx_cnt_r   <= 4'h0;
      tx_bit_r   <= 3'h0;
    end
    else
    begin
      tx_st_r    <= tx_st_nxt;
      thr_full_r <= wr_data | (thr_full_r & ~tx_load);                       // R12
      tx_cnt_r   <= tx_load ? 4'h0 : (tick ? 4'(tx_cnt_r + 4'h1) : tx_cnt_r);
      if (tx_load)
        tx_bit_r <= 3'h0;
      else if (tx_bend && tx_st_r == TX_DATA)
        tx_bit_r <= 3'(tx_bit_r + 3'h1);
    end
    if (wr_data)
      thr_r <= wb_dat_i[7:0];
    if (tx_load)
    begin
      tsr_r    <= thr_r;
      tx_par_r <= parity_bit(thr_r, cfg_r[CFG_PAR_EVEN]);
    end
    else if (tx_bend && tx_st_r == TX_DATA)
      tsr_r <= {1'b0, tsr_r[7:1]};
  end

  // ***************************************************************
  // Receive line: loopback and infrared decoder
  // ***************************************************************
  logic [3:0] ir_low_r;

  wire ir_in     = rx_i ^ cfg_r[CFG_IR_INV];
  wire ir_serial = ~ir_in & (ir_low_r == 4'h0);
  wire rx_line   = loop_en ? tx_serial : (ir_en ? ir_serial : rx_i);          // R24 R4

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
      ir_low_r <= 4'h0;
    else if (ir_in)
      ir_low_r <= BIT_LAST;
    else if (tick && ir_low_r != 4'h0)
      ir_low_r <= 4'(ir_low_r - 4'h1);
  end

  // ***************************************************************
  // Receiver
  // ***************************************************************
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRKWAIT} uml_rx_st_t;
  uml_rx_st_t rx_st_r;
  logic [3:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_pe_r;
  logic       rx_zero_r;

  wire rx_mid   = tick & (rx_cnt_r == SAMPLE_MID) & (rx_st_r == RX_START);
  wire rx_bend  = tick & (rx_cnt_r == BIT_LAST);
  wire rx_done  = rx_bend & (rx_st_r == RX_STOP);
  wire rx_brk   = rx_zero_r & ~rx_line;                                       // R11
  uml_rx_char_t rx_char;
  assign rx_char = '{brk: rx_brk, fe: ~rx_line, pe: rx_pe_r, data: rx_sh_r};  // R10

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 4'h0;
    end
    else
    begin
      rx_cnt_r <= (rx_st_r == RX_IDLE || rx_mid) ? 4'h0 : (tick ? 4'(rx_cnt_r + 4'h1) : rx_cnt_r);
      case (rx_st_r)
        RX_IDLE:
        begin
          rx_zero_r <= 1'b1;
          rx_pe_r   <= 1'b0;
          rx_bit_r  <= 3'h0;
          if (!rx_line)
            rx_st_r <= RX_START;
        end
        RX_START:
        begin
          if (rx_mid)
            rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
        end
        RX_DATA:
        begin
          if (rx_bend)
          begin
            rx_sh_r   <= {rx_line, rx_sh_r[7:1]};
            rx_zero_r <= rx_zero_r & ~rx_line;
            rx_bit_r  <= 3'(rx_bit_r + 3'h1);
            if (rx_bit_r == 3'h7)
              rx_st_r <= cfg_r[CFG_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          if (rx_bend)
          begin
            rx_pe_r   <= rx_line ^ parity_bit(rx_sh_r, cfg_r[CFG_PAR_EVEN]);
            rx_zero_r <= rx_zero_r & ~rx_line;
            rx_st_r   <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (rx_bend)
            rx_st_r <= rx_brk ? RX_BRKWAIT : RX_IDLE;                        // R11
        end
        RX_BRKWAIT:
        begin
          if (rx_line)
            rx_st_r <= RX_IDLE;
        end
        default:
        begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Receive FIFO and error accounting
  // ***************************************************************
  uml_rx_char_t     fifo_mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] fifo_cnt_r;
  logic [CNT_W-1:0] err_cnt_r;
  logic             tags_clr_r;
  logic             ovr_r;

  uml_rx_char_t head;
  assign head = fifo_mem[rd_ptr_r];

  wire [CNT_W-1:0] fifo_cap = cfg_r[CFG_FIFO_EN] ? CNT_W'(RX_DEPTH) : CNT_W'(1);
  wire fifo_nempty = fifo_cnt_r != '0;
  wire fifo_full   = fifo_cnt_r >= fifo_cap;
  wire push        = rx_done & ~fifo_full;                                    // R9
  wire pop         = rd_data & fifo_nempty;
  wire push_err    = push & (rx_char.brk | rx_char.fe | rx_char.pe);
  wire pop_err     = pop & (head.brk | head.fe | head.pe);
  wire head_new    = pop | (push & ~fifo_nempty);
  wire [2:0] tags  = {head.brk, head.fe, head.pe} & {3{fifo_nempty & ~tags_clr_r}}; // R10

  always_ff @(posedge clk_i)
  begin
    if (push)
      fifo_mem[wr_ptr_r] <= rx_char;
    if (core_rst)
    begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      fifo_cnt_r <= '0;
      err_cnt_r  <= '0;
      tags_clr_r <= 1'b0;
      ovr_r      <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (pop)
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      fifo_cnt_r <= CNT_W'(fifo_cnt_r + CNT_W'(push) - CNT_W'(pop));
      err_cnt_r  <= CNT_W'(err_cnt_r + CNT_W'(push_err) - CNT_W'(pop_err));   // R15
      tags_clr_r <= ~head_new & (tags_clr_r | rd_lsr);                        // R7
      ovr_r      <= (rx_done & fifo_full) | (ovr_r & ~rd_lsr);                // R9 R7
    end
  end

  wire thre    = ~thr_full_r;                                                 // R12
  wire temt    = ~thr_full_r & tx_idle;                                       // R14
  wire [7:0] lsr_val = {err_cnt_r != '0, temt, thre, tags, ovr_r, fifo_nempty}; // R8 R15

  // ***************************************************************
  // Control registers
  // ***************************************************************
  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      ier_r <= IER_RST;
      mcr_r <= {1'b0, ir_strap_i, MCR_LOW_RST};                               // R3
      cfg_r <= CFG_RST;
      div_r <= DIV_W'(DIV_RST);
    end
    else
    begin
      if (wr_req && hit_ier)
        ier_r <= wb_dat_i[3:0];
      if (wr_req && hit_mcr)
        mcr_r <= wb_dat_i[7:0];                                               // R1 R22
      if (wr_req && hit_cfg)
        cfg_r <= wb_dat_i[7:0];
      else if (rx_done && mcr_r[MCR_XON_ANY])
        cfg_r[CFG_SW_HALT] <= 1'b0;                                           // R2
      if (wr_req && hit_div)
        div_r <= {(wb_sel_i[1] ? wb_dat_i[15:8] : div_r[15:8]), wb_dat_i[7:0]};
    end
  end

  // ***************************************************************
  // Read data, pins and interrupt
  // ***************************************************************
  wire [15:0] rd_mux = hit_data ? {8'h00, head.data} :
                       hit_ier  ? {12'h000, ier_r} :
                       hit_mcr  ? {8'h00, mcr_r} :
                       hit_lsr  ? {8'h00, lsr_val} :
                       hit_msr  ? {8'h00, msr_val} :
                       hit_cfg  ? {8'h00, cfg_r} :
                       hit_div  ? div_r : 16'h0000;

  wire irq_nxt = (ier_r[IER_LS] & (ovr_r | (|tags) | (err_cnt_r != '0)))      // R6
               | (ier_r[IER_THR] & thre)                                      // R13
               | (ier_r[IER_MS] & (|delta_r))                                 // R18
               | (ier_r[IER_RX] & fifo_nempty);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h00000000;
    else if (rd_req)
      dat_r <= {16'h0000, rd_mux};
    if (core_rst)
    begin
      tx_o    <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      irq_o   <= 1'b0;
    end
    else
    begin
      tx_o    <= tx_pin;
      rts_n_o <= loop_en | ~mcr_r[MCR_RTS];                                   // R23 R24
      dtr_n_o <= loop_en | ~mcr_r[MCR_DTR];                                   // R23 R24
      irq_o   <= irq_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : uml_channel

`default_nettype wire

//--- sim/uml_remote.sv
`timescale 1ns/1ps
`default_nettype none

module uml_remote
  import uml_pkg::*;
#(
  parameter int BIT = 16
) (
  input  wire logic        clk_i,
  output logic             rx_o,
  output var uml_modem_in_t modem_o
);
  // ****************************************
  // Remote serial peer and handshake lines
  // ****************************************
  initial
  begin
    rx_o    = 1'b1;
    modem_o = 4'hf;
  end

  // Handshake levels; a high clear-to-send pauses the far transmitter.
  task automatic modem(input uml_modem_in_t v);
    @(posedge clk_i);
    modem_o <= v;
  endtask : modem

  // LSB first; p[1] adds a parity bit of value p[0]; s is the stop level.
  task automatic frame(input logic [7:0] d, input logic [1:0] p, input logic s);
    logic [10:0] f;
    f = p[1] ? {s, p[0], d, 1'b0} : {1'b1, s, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk_i);
      rx_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask : frame
  task automatic brk();
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (BIT * 25) @(posedge clk_i);
    rx_o <= 1'b1;
    repeat (BIT * 2) @(posedge clk_i);
  endtask : brk
endmodule : uml_remote

`default_nettype wire

//--- sim/uml_channel_properties.sv
`timescale 1ns/1ps
`default_nettype none

module uml_channel_properties
  import uml_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 64,
  parameter int unsigned DIV_W    = 16
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              tx_o,
  input wire uml_modem_in_t     modem_i,
  input wire logic              rts_n_o,
  input wire logic              dtr_n_o,
  input wire logic              ir_strap_i
);
  logic [7:0] mcr_r;

  wire        wr_w = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire        rd_w = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;

  // Mirror of the control register as software last set it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (wr_w && wb_adr_i == OFF_SRST && wb_dat_i[0]))
      mcr_r <= {1'b0, ir_strap_i, 6'h00};
    else if (wr_w && wb_adr_i == OFF_MCR)
      mcr_r <= wb_dat_i[7:0];
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence mcr_wr_s;
    wr_w && wb_adr_i == OFF_MCR;
  endsequence
  sequence rd_s(logic [5:0] a);
    rd_w && wb_adr_i == a;
  endsequence

  ack_turn_a: assert property (req_s |=> wb_ack_o)
    else $error("request not answered after one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");
  rts_drive_a: assert property (mcr_wr_s |-> ##2 rts_n_o == !(mcr_r[1] && !mcr_r[4]))
    else $error("send request pin wrong");
  dtr_drive_a: assert property (mcr_wr_s |-> ##2 dtr_n_o == !(mcr_r[0] && !mcr_r[4]))
    else $error("terminal ready pin wrong");
  loop_pins_a: assert property (mcr_wr_s ##0 wb_dat_i[4]
    |-> ##2 (rts_n_o && dtr_n_o && tx_o == !mcr_r[6])[*4])
    else $error("pins active in loopback");
  mcr_read_a: assert property (rd_s(OFF_MCR) |-> wb_dat_o[7:0] == mcr_r)
    else $error("control register read back wrong");
  msr_pins_a: assert property (rd_s(OFF_MSR) ##0 !mcr_r[4] |-> wb_dat_o[7:4] == ~modem_i)
    else $error("modem levels not inverted inputs");
  msr_loop_a: assert property (rd_s(OFF_MSR) ##0 mcr_r[4]
    |-> wb_dat_o[7:4] == {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]})
    else $error("loopback modem levels wrong");
  lsr_clear_a: assert property (rd_s(OFF_LSR) ##[3:4] rd_s(OFF_LSR) |-> wb_dat_o[4:1] == 4'h0)
    else $error("line status not cleared by read");
endmodule : uml_channel_properties

bind uml_channel uml_channel_properties #(.RX_DEPTH(RX_DEPTH), .DIV_W(DIV_W)) props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_o(tx_o), .modem_i(modem_i),
  .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .ir_strap_i(ir_strap_i));

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import uml_pkg::*;
;
  localparam int BIT   = 16;
  localparam int LIMIT = 20000;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cyc   = 1'b0;
  logic          stb   = 1'b0;
  logic          we    = 1'b0;
  logic [5:0]    adr   = 6'h00;
  logic [31:0]   dat   = 32'h00000000;
  logic          strap = 1'b1;
  logic [3:0]    sel   = 4'h1;
  wire logic [31:0] dat_o;
  wire logic     ack;
  wire logic     rx;
  wire logic     tx;
  wire logic     rts_n;
  wire logic     dtr_n;
  wire logic     irq;
  uml_modem_in_t modem;
  logic [7:0]    q;
  int            w;
  int            n;
  int            cycles = 0;
  int            miscompares = 0;
  int            checked = 0;
  always #10 clk_i = ~clk_i;
  uml_channel #(.RX_DEPTH(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_i(rx), .tx_o(tx), .modem_i(modem),
    .rts_n_o(rts_n), .dtr_n_o(dtr_n), .ir_strap_i(strap), .irq_o(irq));
  uml_remote #(.BIT(BIT)) rm (.clk_i(clk_i), .rx_o(rx), .modem_o(modem));

  // ****************************************
  // Bus cycles and comparisons
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w_en, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w_en;
    adr <= a;
    dat <= {24'h000000, d};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20) miscompares++;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rc

  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 400; i++)
    begin
      bus(1'b0, OFF_LSR, 8'h00);
      if ((q & m) == m) break;
    end
  endtask : poll

  // Waits for the next start bit and measures how long the line stays low.
  task automatic pulse();
    w = 0;
    n = 0;
    while (tx !== 1'b0 && w < 2000)
    begin
      @(posedge clk_i);
      w++;
    end
    while (tx === 1'b0 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : pulse

  task automatic done(input int t);
    $display("test %0d finished", t);
  endtask : done

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(OFF_MCR, 8'h40);
    chk({7'h00, tx}, 8'h00);
    strap <= 1'b0;
    wr(OFF_SRST, 8'h01);
    repeat (3) @(posedge clk_i);
    rc(OFF_MCR, 8'h00);
    rc(OFF_LSR, 8'h60);
    rc(OFF_MSR, 8'h00);
    done(1);
    rm.modem(4'h0);
    repeat (5) @(posedge clk_i);
    rc(OFF_MSR, 8'hfb);
    rc(OFF_MSR, 8'hf0);
    wr(OFF_IER, 8'h08);
    rm.modem(4'h4);
    repeat (5) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    rc(OFF_MSR, 8'hb4);
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h00);
    wr(OFF_IER, 8'h00);
    rm.modem(4'h0);
    repeat (5) @(posedge clk_i);
    rc(OFF_MSR, 8'hf0);
    done(2);
    wr(OFF_MCR, 8'h03);
    @(posedge clk_i);
    chk({6'h00, rts_n, dtr_n}, 8'h00);
    wr(OFF_MCR, 8'h1f);
    bus(1'b0, OFF_MSR, 8'h00);
    chk({6'h00, rts_n, dtr_n}, 8'h03);
    chk(q & 8'hf0, 8'hf0);
    wr(OFF_MCR, 8'h16);
    bus(1'b0, OFF_MSR, 8'h00);
    chk(q & 8'hf0, 8'h50);
    rc(OFF_MCR, 8'h16);
    wr(OFF_DATA, 8'ha5);
    repeat (40) @(posedge clk_i);
    chk({7'h00, tx}, 8'h01);
    poll(8'h01);
    rc(OFF_DATA, 8'ha5);
    wr(OFF_MCR, 8'h00);
    done(3);
    wr(OFF_MCR, 8'h80);
    wr(OFF_DATA, 8'h00);
    pulse();
    chk(8'(n / 4), 8'h90);
    poll(8'h40);
    wr(OFF_MCR, 8'h00);
    done(4);
    wr(OFF_DATA, 8'h55);
    bus(1'b0, OFF_LSR, 8'h00);
    chk(q & 8'h60, 8'h20);
    wr(OFF_DATA, 8'h66);
    bus(1'b0, OFF_LSR, 8'h00);
    chk(q & 8'h60, 8'h00);
    wr(OFF_IER, 8'h02);
    chk({7'h00, irq}, 8'h00);
    poll(8'h20);
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    wr(OFF_IER, 8'h00);
    poll(8'h40);
    done(5);
    wr(OFF_CFG, 8'h02);
    rm.modem(4'h1);
    repeat (5) @(posedge clk_i);
    wr(OFF_DATA, 8'h00);
    repeat (300) @(posedge clk_i);
    chk({7'h00, tx}, 8'h01);
    rm.modem(4'h0);
    pulse();
    chk({7'h00, w < 40}, 8'h01);
    chk(8'(n), 8'h90);
    poll(8'h40);
    wr(OFF_CFG, 8'h20);
    wr(OFF_MCR, 8'h20);
    wr(OFF_DATA, 8'h00);
    repeat (300) @(posedge clk_i);
    chk({7'h00, tx}, 8'h01);
    rm.frame(8'h11, 2'b00, 1'b1);
    pulse();
    chk({7'h00, w < 40}, 8'h01);
    rc(OFF_DATA, 8'h11);
    wr(OFF_MCR, 8'h00);
    poll(8'h40);
    done(6);
    wr(OFF_CFG, 8'h08);
    wr(OFF_IER, 8'h04);
    rm.frame(8'h01, 2'b11, 1'b1);
    repeat (20) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    rc(OFF_LSR, 8'he5);
    rc(OFF_LSR, 8'he1);
    rc(OFF_DATA, 8'h01);
    rc(OFF_LSR, 8'h60);
    chk({7'h00, irq}, 8'h00);
    wr(OFF_CFG, 8'h00);
    rm.frame(8'h3c, 2'b00, 1'b0);
    repeat (20) @(posedge clk_i);
    rc(OFF_LSR, 8'he9);
    rc(OFF_DATA, 8'h3c);
    rm.brk();
    rc(OFF_LSR, 8'hf9);
    rc(OFF_DATA, 8'h00);
    rc(OFF_LSR, 8'h60);
    wr(OFF_IER, 8'h00);
    done(7);
    wr(OFF_CFG, 8'h01);
    for (int i = 1; i < 6; i++) rm.frame(8'(i), 2'b00, 1'b1);
    repeat (20) @(posedge clk_i);
    rc(OFF_LSR, 8'h63);
    for (int i = 1; i < 5; i++) rc(OFF_DATA, 8'(i));
    rc(OFF_LSR, 8'h60);
    sel <= 4'h0;
    wr(OFF_MCR, 8'h10);
    rc(OFF_MCR, 8'h00);
    done(8);
    results();
  end
endmodule : testbench

`default_nettype wire
